/* inc/uam_params.svh */
// Purpose: Offsets, field positions, reset values and widths for the address match block.
// Assumes: Byte-wide registers on an 8-bit special-function address space.
// Notes: Included by the package and the design modules.
`ifndef UAM_PARAMS_SVH
`define UAM_PARAMS_SVH

`define UAM_ADDR_W 8
`define UAM_DATA_W 8
`define UAM_OFF_AUX_CONTROL_ONE 8'hA2
`define UAM_OFF_SERIAL0_OWN_ADDRESS 8'hA9
`define UAM_OFF_SERIAL0_ADDRESS_MASK 8'hB9
`define UAM_OFF_SERIAL1_ADDRESS_MASK 8'hBA
`define UAM_OFF_SERIAL1_OWN_ADDRESS 8'hBB
`define UAM_RST_BYTE 8'h00
`define UAM_AUX_SWRF_BIT 7
`define UAM_AUX_RSTPIN_BIT 6
`define UAM_AUX_HARD_BIT 5
`define UAM_AUX_GF2_BIT 3
`define UAM_AUX_PINSWAP_BIT 2
`define UAM_AUX_DPS_BIT 0
`define UAM_AUX_WMASK 8'hED
`define UAM_CHANNELS 2

`endif

/* inc/uam_pkg.sv */
// Purpose: Types shared by the address match block.
// Assumes: Constants come from the params header.
// Notes: Register selector for the write and read paths.
`include "uam_params.svh"
package uam_pkg;
    typedef logic [`UAM_DATA_W-1:0] uam_byte_type;
    typedef enum logic [2:0] {
        UAM_SEL_NONE = 3'h0,
        UAM_SEL_AUX = 3'h1,
        UAM_SEL_OWN0 = 3'h3,
        UAM_SEL_MASK0 = 3'h2,
        UAM_SEL_MASK1 = 3'h6,
        UAM_SEL_OWN1 = 3'h7
    } uam_sel_type;
endpackage

/* rtl/uam_match.sv */
// Purpose: Given-address comparison for one serial channel.
// Assumes: Mask bit one means the address bit takes part in the comparison.
// Notes: Purely combinational.
`include "uam_params.svh"
module uam_match
    import uam_pkg::*;
(
    // Configuration.
    input wire uam_byte_type ownAddr,
    input wire uam_byte_type addrMask,
    // Received address byte and result.
    input wire uam_byte_type rxAddr,
    output logic isMatch
);
    // Masked bits must agree; zero mask bits are don't-care.
    always_comb begin
        isMatch = (((rxAddr ^ ownAddr) & addrMask) == `UAM_RST_BYTE);
    end
endmodule

/* rtl/uam_addr_match_pin_swap.sv */
// Purpose: Address recognition registers for two serial channels and channel 0 pin exchange.
// Assumes: Register port with one-cycle strobes, read data in the following cycle.
// Notes: Frame logic stays outside; it presents received address bytes here.
//
// Design decision made here: strobed register access.
`include "uam_params.svh"
module uam_addr_match_pin_swap
    import uam_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register port.
    input wire logic [`UAM_ADDR_W-1:0] regAddr,
    input wire uam_byte_type regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output uam_byte_type regRdata,
    // Reset cause inputs, one-cycle pulses from the reset system.
    input wire logic swResetSeen,
    input wire logic pinResetSeen,
    input wire logic hardFaultSeen,
    // Received address bytes from the frame logic.
    input wire uam_byte_type rxAddr0,
    input wire uam_byte_type rxAddr1,
    output logic addrMatch0,
    output logic addrMatch1,
    // Channel 0 serial data on the core side.
    input wire logic txData0,
    output logic rxData0,
    // Port pins P0.7 and P0.6.
    input wire logic pinP07In,
    input wire logic pinP06In,
    output logic pinP07Out,
    output logic pinP07Oe,
    output logic pinP06Out,
    output logic pinP06Oe,
    // Channel 0 pin exchange state.
    output logic serial0PinSwap
);
    // Stored register state outside the per-channel blocks.
    uam_byte_type regRdata_r;
    logic swResetFlag_r;
    logic pinResetFlag_r;
    logic hardFaultFlag_r;
    logic generalFlag_r;
    logic pinSwap_r;
    logic dataPtrSel_r;

    // Decoded access and next values.
    uam_sel_type sel;
    logic auxWrite;
    logic [`UAM_CHANNELS-1:0] ownWrite;
    logic [`UAM_CHANNELS-1:0] maskWrite;
    uam_byte_type auxWdata;
    uam_byte_type auxReadValue;
    uam_byte_type regRdata_nxt;

    // Per-channel views of the address registers and comparators.
    wire uam_byte_type ownAddr [`UAM_CHANNELS];
    wire uam_byte_type addrMask [`UAM_CHANNELS];
    wire uam_byte_type rxAddr [`UAM_CHANNELS];
    wire logic [`UAM_CHANNELS-1:0] match;

    // Decodes the register address.
    // Unmapped offsets select nothing, so writes drop and reads return zero.
    always_comb begin
        unique case (regAddr)
            `UAM_OFF_AUX_CONTROL_ONE: begin
                sel = UAM_SEL_AUX;
            end
            `UAM_OFF_SERIAL0_OWN_ADDRESS: begin
                sel = UAM_SEL_OWN0;
            end
            `UAM_OFF_SERIAL0_ADDRESS_MASK: begin
                sel = UAM_SEL_MASK0;
            end
            `UAM_OFF_SERIAL1_ADDRESS_MASK: begin
                sel = UAM_SEL_MASK1;
            end
            `UAM_OFF_SERIAL1_OWN_ADDRESS: begin
                sel = UAM_SEL_OWN1;
            end
            default: begin
                sel = UAM_SEL_NONE;
            end
        endcase
    end

    // Turns the selector into one write enable per register.
    always_comb begin
        auxWrite = 1'b0;
        ownWrite = '0;
        maskWrite = '0;
        if (regWrite) begin
            unique case (sel)
                UAM_SEL_AUX: begin
                    auxWrite = 1'b1;
                end
                UAM_SEL_OWN0: begin
                    ownWrite[0] = 1'b1;
                end
                UAM_SEL_MASK0: begin
                    maskWrite[0] = 1'b1;
                end
                UAM_SEL_OWN1: begin
                    ownWrite[1] = 1'b1;
                end
                UAM_SEL_MASK1: begin
                    maskWrite[1] = 1'b1;
                end
                UAM_SEL_NONE: begin
                    auxWrite = 1'b0;
                end
            endcase
        end
    end

    // Bits 4 and 1 of the auxiliary register are not writable.
    assign auxWdata = regWdata & `UAM_AUX_WMASK;

    // One register pair and one comparator per channel.
    for (genvar ch = 0; ch < `UAM_CHANNELS; ch++) begin : gChannel
        uam_byte_type ownAddr_r;
        uam_byte_type addrMask_r;

        // Own address of this channel.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                ownAddr_r <= `UAM_RST_BYTE;
            end else if (ownWrite[ch]) begin
                ownAddr_r <= regWdata;
            end
        end

        // Address mask of this channel; zero bits are don't-care.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                addrMask_r <= `UAM_RST_BYTE;
            end else if (maskWrite[ch]) begin
                addrMask_r <= regWdata;
            end
        end

        assign ownAddr[ch] = ownAddr_r;
        assign addrMask[ch] = addrMask_r;

        // A reset mask of zero makes every address byte match.
        uam_match uMatch (
            .ownAddr(ownAddr_r),
            .addrMask(addrMask_r),
            .rxAddr(rxAddr[ch]),
            .isMatch(match[ch])
        );
    end

    // Received address bytes come from the frame logic of each channel.
    assign rxAddr[0] = rxAddr0;
    assign rxAddr[1] = rxAddr1;

    assign addrMatch0 = match[0];
    assign addrMatch1 = match[1];

    // Software reset flag: set by hardware, writable by software; a set beats a clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swResetFlag_r <= 1'b0;
        end else if (swResetSeen) begin
            swResetFlag_r <= 1'b1;
        end else if (auxWrite) begin
            swResetFlag_r <= auxWdata[`UAM_AUX_SWRF_BIT];
        end
    end

    // Pin reset flag: set by hardware, writable by software; a set beats a clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinResetFlag_r <= 1'b0;
        end else if (pinResetSeen) begin
            pinResetFlag_r <= 1'b1;
        end else if (auxWrite) begin
            pinResetFlag_r <= auxWdata[`UAM_AUX_RSTPIN_BIT];
        end
    end

    // Hard fault flag: set by hardware, writable by software; a set beats a clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hardFaultFlag_r <= 1'b0;
        end else if (hardFaultSeen) begin
            hardFaultFlag_r <= 1'b1;
        end else if (auxWrite) begin
            hardFaultFlag_r <= auxWdata[`UAM_AUX_HARD_BIT];
        end
    end

    // General-purpose flag, software only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            generalFlag_r <= 1'b0;
        end else if (auxWrite) begin
            generalFlag_r <= auxWdata[`UAM_AUX_GF2_BIT];
        end
    end

    // Channel 0 pin exchange control, software only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinSwap_r <= 1'b0;
        end else if (auxWrite) begin
            pinSwap_r <= auxWdata[`UAM_AUX_PINSWAP_BIT];
        end
    end

    // Data pointer select, software only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dataPtrSel_r <= 1'b0;
        end else if (auxWrite) begin
            dataPtrSel_r <= auxWdata[`UAM_AUX_DPS_BIT];
        end
    end

    // Assembles the auxiliary register; unused bits read zero.
    always_comb begin
        auxReadValue = `UAM_RST_BYTE;
        auxReadValue[`UAM_AUX_SWRF_BIT] = swResetFlag_r;
        auxReadValue[`UAM_AUX_RSTPIN_BIT] = pinResetFlag_r;
        auxReadValue[`UAM_AUX_HARD_BIT] = hardFaultFlag_r;
        auxReadValue[`UAM_AUX_GF2_BIT] = generalFlag_r;
        auxReadValue[`UAM_AUX_PINSWAP_BIT] = pinSwap_r;
        auxReadValue[`UAM_AUX_DPS_BIT] = dataPtrSel_r;
    end

    // Selects the read value; zero when no read is asked for.
    always_comb begin
        regRdata_nxt = `UAM_RST_BYTE;
        if (regRead) begin
            unique case (sel)
                UAM_SEL_AUX: begin
                    regRdata_nxt = auxReadValue;
                end
                UAM_SEL_OWN0: begin
                    regRdata_nxt = ownAddr[0];
                end
                UAM_SEL_MASK0: begin
                    regRdata_nxt = addrMask[0];
                end
                UAM_SEL_MASK1: begin
                    regRdata_nxt = addrMask[1];
                end
                UAM_SEL_OWN1: begin
                    regRdata_nxt = ownAddr[1];
                end
                UAM_SEL_NONE: begin
                    regRdata_nxt = `UAM_RST_BYTE;
                end
            endcase
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= `UAM_RST_BYTE;
        end else begin
            regRdata_r <= regRdata_nxt;
        end
    end

    assign regRdata = regRdata_r;

    // Pin routing follows the swap bit combinationally, with no wait for a frame end.
    // Changing it in the middle of a character corrupts that character.
    assign serial0PinSwap = pinSwap_r;

    // Both pins carry the transmit bit; the output enable picks the driving pin.
    always_comb begin
        pinP06Out = txData0;
        pinP07Out = txData0;
        if (serial0PinSwap) begin
            rxData0 = pinP06In;
            pinP06Oe = 1'b0;
            pinP07Oe = 1'b1;
        end else begin
            rxData0 = pinP07In;
            pinP06Oe = 1'b1;
            pinP07Oe = 1'b0;
        end
    end
endmodule

/* verification/uam_chk.sv */
// Purpose: Assertions for the address match block.
// Assumes: One-cycle strobes, read data in the next cycle.
// Notes: Bound to the top module.
module uam_chk
    import uam_pkg::*;
(
    // Clock, reset and register port.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire uam_byte_type regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire uam_byte_type regRdata,
    // Channel 0 pins.
    input wire logic addrMatch0,
    input wire logic txData0,
    input wire logic rxData0,
    input wire logic pinP07In,
    input wire logic pinP06In,
    input wire logic pinP07Out,
    input wire logic pinP07Oe,
    input wire logic pinP06Out,
    input wire logic pinP06Oe,
    input wire logic serial0PinSwap
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_rx_route: assert property (rxData0 == (serial0PinSwap ? pinP06In : pinP07In))
        else $error("receive routing wrong");
    a_oe_split: assert property (pinP06Oe == !serial0PinSwap && pinP07Oe == serial0PinSwap)
        else $error("pin enables wrong");
    a_tx_pins: assert property (pinP06Out == txData0 && pinP07Out == txData0)
        else $error("transmit pins wrong");
    a_swap_now: assert property (regWrite && regAddr == 8'hA2 |=> serial0PinSwap == $past(regWdata[2]))
        else $error("swap not applied");
    a_swap_hold: assert property (!(regWrite && regAddr == 8'hA2) |=> $stable(serial0PinSwap))
        else $error("swap changed alone");
    a_rd_idle: assert property (!regRead |=> regRdata == 8'h00)
        else $error("read data outside slot");
    a_aux_read: assert property (regRead && regAddr == 8'hA2 |=> (regRdata & 8'h16) == {5'h00, serial0PinSwap, 2'h0})
        else $error("aux read wrong");
    a_wr_rd: assert property (regWrite && regAddr inside {8'hA9, 8'hB9, 8'hBA, 8'hBB} ##1 regRead && $stable(regAddr) |=> regRdata == $past(regWdata, 2))
        else $error("address byte readback wrong");
    c_swap: cover property ($rose(serial0PinSwap));
    c_nomatch: cover property ($fell(addrMatch0));
    c_wr_rd: cover property (regWrite ##1 regRead);
endmodule

bind uam_addr_match_pin_swap uam_chk u_uam_chk (.mclk, .rst_n, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .addrMatch0, .txData0, .rxData0, .pinP07In, .pinP06In, .pinP07Out,
    .pinP07Oe, .pinP06Out, .pinP06Oe, .serial0PinSwap);

/* verification/uam_peer.sv */
// Purpose: Far-side processor on the channel 0 lines.
// Assumes: It puts the data bit only on the device's receive pin.
// Notes: The other line shows the inverse, so no stale level passes.
module uam_peer (
    // Routing and bit sent.
    input wire logic swap,
    input wire logic bitOut,
    // Line levels.
    output logic line07,
    output logic line06
);
    timeunit 1ns;
    timeprecision 1ns;
    // The bench changes swap only between characters.
    assign line07 = swap ? ~bitOut : bitOut;
    assign line06 = swap ? bitOut : ~bitOut;
endmodule

/* verification/test_uart_addr_match_pin_swap.sv */
// Purpose: Self-checking bench for the address match block.
// Assumes: Register model kept in an int array.
// Notes: Pin levels resolved from enables and the peer.
`include "uam_params.svh"
module test_uart_addr_match_pin_swap
    import uam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_n = 0, regWrite = 0, regRead = 0, txData0 = 0, peerBit = 0;
    logic [7:0] regAddr = 8'h00;
    uam_byte_type regWdata = 8'h00, rxAddr0 = 8'h00, rxAddr1 = 8'h00, regRdata;
    logic addrMatch0, addrMatch1, rxData0, pinP07Out, pinP07Oe, pinP06Out, pinP06Oe;
    logic serial0PinSwap, peer07, peer06;
    int n_errors = 0, comparisons = 0, mdl[256];
    logic [31:0] seed = 32'he70f_c6e7;
    logic [7:0] offs[6] = '{8'hA2, 8'hA9, 8'hB9, 8'hBA, 8'hBB, 8'h5C};
    wire logic pinP07In = pinP07Oe ? pinP07Out : peer07;
    wire logic pinP06In = pinP06Oe ? pinP06Out : peer06;
    uam_peer u_uam_peer (.swap(serial0PinSwap), .bitOut(peerBit), .line07(peer07), .line06(peer06));
    uam_addr_match_pin_swap u_uam_addr_match_pin_swap (.mclk, .rst_n, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .swResetSeen(1'b0), .pinResetSeen(1'b0),
        .hardFaultSeen(1'b0), .rxAddr0, .rxAddr1, .addrMatch0, .addrMatch1, .txData0, .rxData0,
        .pinP07In, .pinP06In, .pinP07Out, .pinP07Oe, .pinP06Out, .pinP06Oe, .serial0PinSwap);
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wrd(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        if (a inside {8'hA2, 8'hA9, 8'hB9, 8'hBA, 8'hBB})
            mdl[a] = (a == 8'hA2) ? (d & `UAM_AUX_WMASK) : d;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, mdl[a]);
    endtask
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (2000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk(addrMatch0 & addrMatch1, 1);
        chk(pinP06Oe, 1);
        $display("test reset done");
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            wrd(offs[seed[2:0] % 6], seed[15:8]);
            @(posedge mclk);
            rxAddr0 <= seed[23:16];
            rxAddr1 <= seed[31:24];
            txData0 <= seed[3];
            peerBit <= seed[4];
            @(posedge mclk);
            #1;
            chk(addrMatch0, ((rxAddr0 ^ mdl['hA9]) & mdl['hB9]) == 0);
            chk(addrMatch1, ((rxAddr1 ^ mdl['hBB]) & mdl['hBA]) == 0);
            chk(rxData0, peerBit);
            chk(mdl['hA2][2] ? pinP07Out : pinP06Out, txData0);
            chk(mdl['hA2][2] ? pinP07Oe : pinP06Oe, 1);
            chk(mdl['hA2][2] ? pinP06Oe : pinP07Oe, 0);
        end
        $display("test random access done");
        tally_and_finish();
    end
endmodule
